/* File: hw/msx_pkg.sv */
// Shared constants and types for the move and shift instruction execution block.
package msx_pkg;

  localparam int PTR_W = 16;
  localparam int BANK_W = 5;
  localparam int LATCH_W = 7;
  localparam int FADDR_W = 7;
  localparam int OFFS_W = 6;

  // Register port byte offsets.
  localparam logic [3:0] REG_WORK = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_BANK = 4'h2;
  localparam logic [3:0] REG_LATCH = 4'h3;
  localparam logic [3:0] REG_PTR0_LO = 4'h4;
  localparam logic [3:0] REG_PTR0_HI = 4'h5;
  localparam logic [3:0] REG_PTR1_LO = 4'h6;
  localparam logic [3:0] REG_PTR1_HI = 4'h7;

  // Status register field positions.
  localparam int STATUS_C_BIT = 0;
  localparam int STATUS_Z_BIT = 1;

  // Reset values.
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [BANK_W-1:0] BANK_RESET = 5'h00;
  localparam logic [LATCH_W-1:0] LATCH_RESET = 7'h00;
  localparam logic [PTR_W-1:0] PTR_RESET = 16'h0000;

  // File addresses that stand for the two indirect ports.
  localparam logic [FADDR_W-1:0] INDIRECT_PORT0_ADDR = 7'h00;
  localparam logic [FADDR_W-1:0] INDIRECT_PORT1_ADDR = 7'h01;

  typedef enum logic [2:0] {
    no_op = 3'h0,
    logical_right_shift_op = 3'h1,
    file_move_op = 3'h2,
    indirect_load_op = 3'h3,
    bank_literal_load_op = 3'h4,
    pc_latch_literal_load_op = 3'h5,
    accumulator_literal_load_op = 3'h6
  } op_t;

  typedef enum logic [1:0] {
    mode_pre_inc = 2'b00,
    mode_pre_dec = 2'b01,
    mode_post_inc = 2'b10,
    mode_post_dec = 2'b11
  } pointer_update_mode_t;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_read = 3'b010,
    st_capture = 3'b100
  } state_t;

endpackage

/* File: hw/pointer_addr_unit.sv */
// Effective address and pointer update for one indirect load.
`timescale 1ns/1ns
module pointer_addr_unit
  import msx_pkg::*;
#(
  parameter int W = PTR_W
) (
  input wire logic [W-1:0] ptr,
  input wire logic [1:0] pointer_update_mode,
  input wire logic relative,
  input wire logic [OFFS_W-1:0] offset,
  output logic [W-1:0] eff_addr,
  output logic [W-1:0] ptr_next
);

  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

  initial begin
    if (W <= OFFS_W) begin
      $error("pointer_addr_unit: pointer width too small");
    end
  end

  logic [W-1:0] inc;
  logic [W-1:0] dec;
  logic [W-1:0] offs_ext;

  // Plain modulo arithmetic gives the wrap at both ends of the range.
  assign inc = ptr + ONE;
  assign dec = ptr - ONE;
  assign offs_ext = {{(W-OFFS_W){offset[OFFS_W-1]}}, offset};

  always_comb begin
    if (relative) begin
      eff_addr = ptr + offs_ext;
      ptr_next = ptr;
    end else begin
      case (pointer_update_mode)
        mode_pre_inc: begin
          eff_addr = inc;
          ptr_next = inc;
        end
        mode_pre_dec: begin
          eff_addr = dec;
          ptr_next = dec;
        end
        mode_post_inc: begin
          eff_addr = ptr;
          ptr_next = inc;
        end
        default: begin
          eff_addr = ptr;
          ptr_next = dec;
        end
      endcase
    end
  end

endmodule

/* File: hw/move_shift_instruction_exec.sv */
// Execution of shift, move, indirect load and literal load instructions.
// Notes on behaviour
// - Shift right moves f<7:1> down; f<0> to carry.
// - Shift result bit 7 zero; carry and zero updated.
// - Shift destination bit picks work register or file.
// - File move copies to work register or in place.
// - File move updates zero even in place.
// - Indirect load reads pointed location into work register.
// - Address is pointer plus/minus one, same, offset.
// - Mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - Relative offset -32..31 added; pointer unchanged.
// - Pointer ends incremented or decremented by one.
// - Indirect port has no storage; redirects via pointer.
// - Pointers are 16 bits and wrap both ways.
// - Bank literal loads bank select, flags untouched.
// - Latch literal loads seven bits, flags untouched.
// - Work literal loads eight bits in one cycle.
// - Pointer update leaves every status flag unchanged.
`timescale 1ns/1ns
module move_shift_instruction_exec
  import msx_pkg::*;
#(
  parameter int BUS_ADDR_W = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic op_valid,
  input wire op_t op_code,
  output logic op_ready,
  output logic op_done,
  input wire logic [FADDR_W-1:0] file_addr,
  input wire logic dest_bit,
  input wire logic [7:0] literal,
  input wire logic ptr_sel,
  input wire logic indirect_relative,
  input wire logic [1:0] pointer_update_mode,
  input wire logic [OFFS_W-1:0] rel_offset,
  output logic [PTR_W-1:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic [BUS_ADDR_W-1:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  output logic [7:0] work_reg,
  output logic [BANK_W-1:0] bank_select_register,
  output logic [LATCH_W-1:0] program_counter_high_latch,
  output logic carry_flag,
  output logic zero_flag
);

  initial begin
    if (BUS_ADDR_W < 3) begin
      $error("move_shift_instruction_exec: register port address too narrow");
    end
  end

  typedef struct packed {
    state_t st;
    logic [7:0] work;
    logic carry;
    logic zero;
    logic [BANK_W-1:0] bank;
    logic [LATCH_W-1:0] latch;
    logic [PTR_W-1:0] ptr0;
    logic [PTR_W-1:0] ptr1;
    op_t op;
    logic dest;
    logic [PTR_W-1:0] maddr;
    logic mrd;
    logic mwr;
    logic [7:0] mwdata;
    logic done;
    logic [7:0] rdata;
  } regs_t;

  regs_t s_r;
  regs_t s_nxt;

  logic [PTR_W-1:0] sel_ptr;
  logic [PTR_W-1:0] eff_addr;
  logic [PTR_W-1:0] ptr_next;
  logic [PTR_W-1:0] file_mem_addr;
  logic [7:0] shift_res;
  logic [BUS_ADDR_W-1:0] bus_idx;

  assign sel_ptr = ptr_sel ? s_r.ptr1 : s_r.ptr0;

  pointer_addr_unit #(
    .W(PTR_W)
  ) u_ptr (
    .ptr(sel_ptr),
    .pointer_update_mode(pointer_update_mode),
    .relative(indirect_relative),
    .offset(rel_offset),
    .eff_addr(eff_addr),
    .ptr_next(ptr_next)
  );

  // The indirect ports hold nothing; their file addresses become the pointer.
  always_comb begin
    if (file_addr == INDIRECT_PORT0_ADDR) begin
      file_mem_addr = s_r.ptr0;
    end else if (file_addr == INDIRECT_PORT1_ADDR) begin
      file_mem_addr = s_r.ptr1;
    end else begin
      file_mem_addr = {{(PTR_W-BANK_W-FADDR_W){1'b0}}, s_r.bank, file_addr};
    end
  end

  assign shift_res = {1'b0, mem_rdata[7:1]};

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.mrd = 1'b0;
    s_nxt.mwr = 1'b0;
    bus_idx = bus_addr;

    // Register port writes come first so an instruction in the same cycle wins.
    if (bus_wr) begin
      if (bus_idx == BUS_ADDR_W'(REG_WORK)) begin
        s_nxt.work = bus_wdata;
      end else if (bus_idx == BUS_ADDR_W'(REG_STATUS)) begin
        s_nxt.carry = bus_wdata[STATUS_C_BIT];
        s_nxt.zero = bus_wdata[STATUS_Z_BIT];
      end else if (bus_idx == BUS_ADDR_W'(REG_BANK)) begin
        s_nxt.bank = bus_wdata[BANK_W-1:0];
      end else if (bus_idx == BUS_ADDR_W'(REG_LATCH)) begin
        s_nxt.latch = bus_wdata[LATCH_W-1:0];
      end else if (bus_idx == BUS_ADDR_W'(REG_PTR0_LO)) begin
        s_nxt.ptr0[7:0] = bus_wdata;
      end else if (bus_idx == BUS_ADDR_W'(REG_PTR0_HI)) begin
        s_nxt.ptr0[15:8] = bus_wdata;
      end else if (bus_idx == BUS_ADDR_W'(REG_PTR1_LO)) begin
        s_nxt.ptr1[7:0] = bus_wdata;
      end else if (bus_idx == BUS_ADDR_W'(REG_PTR1_HI)) begin
        s_nxt.ptr1[15:8] = bus_wdata;
      end
    end

    if (bus_rd) begin
      if (bus_idx == BUS_ADDR_W'(REG_WORK)) begin
        s_nxt.rdata = s_r.work;
      end else if (bus_idx == BUS_ADDR_W'(REG_STATUS)) begin
        s_nxt.rdata = {6'h00, s_r.zero, s_r.carry};
      end else if (bus_idx == BUS_ADDR_W'(REG_BANK)) begin
        s_nxt.rdata = {3'h0, s_r.bank};
      end else if (bus_idx == BUS_ADDR_W'(REG_LATCH)) begin
        s_nxt.rdata = {1'b0, s_r.latch};
      end else if (bus_idx == BUS_ADDR_W'(REG_PTR0_LO)) begin
        s_nxt.rdata = s_r.ptr0[7:0];
      end else if (bus_idx == BUS_ADDR_W'(REG_PTR0_HI)) begin
        s_nxt.rdata = s_r.ptr0[15:8];
      end else if (bus_idx == BUS_ADDR_W'(REG_PTR1_LO)) begin
        s_nxt.rdata = s_r.ptr1[7:0];
      end else if (bus_idx == BUS_ADDR_W'(REG_PTR1_HI)) begin
        s_nxt.rdata = s_r.ptr1[15:8];
      end else begin
        s_nxt.rdata = 8'h00;
      end
    end else begin
      s_nxt.rdata = 8'h00;
    end

    case (s_r.st)
      st_idle: begin
        if (op_valid) begin
          s_nxt.op = op_code;
          s_nxt.dest = dest_bit;
          case (op_code)
            logical_right_shift_op, file_move_op: begin
              s_nxt.maddr = file_mem_addr;
              s_nxt.mrd = 1'b1;
              s_nxt.st = st_read;
            end
            indirect_load_op: begin
              s_nxt.maddr = eff_addr;
              s_nxt.mrd = 1'b1;
              // Flags are not touched here: the pointer step is silent.
              if (ptr_sel) begin
                s_nxt.ptr1 = ptr_next;
              end else begin
                s_nxt.ptr0 = ptr_next;
              end
              s_nxt.st = st_read;
            end
            bank_literal_load_op: begin
              s_nxt.bank = literal[BANK_W-1:0];
              s_nxt.done = 1'b1;
            end
            pc_latch_literal_load_op: begin
              s_nxt.latch = literal[LATCH_W-1:0];
              s_nxt.done = 1'b1;
            end
            accumulator_literal_load_op: begin
              s_nxt.work = literal;
              s_nxt.done = 1'b1;
            end
            default: begin
              s_nxt.done = 1'b1;
            end
          endcase
        end
      end
      st_read: begin
        // Memory answers one cycle after the read strobe.
        s_nxt.st = st_capture;
      end
      st_capture: begin
        s_nxt.st = st_idle;
        s_nxt.done = 1'b1;
        case (s_r.op)
          logical_right_shift_op: begin
            s_nxt.carry = mem_rdata[0];
            s_nxt.zero = (shift_res == 8'h00);
            if (s_r.dest) begin
              s_nxt.mwr = 1'b1;
              s_nxt.mwdata = shift_res;
            end else begin
              s_nxt.work = shift_res;
            end
          end
          file_move_op: begin
            s_nxt.zero = (mem_rdata == 8'h00);
            if (s_r.dest) begin
              s_nxt.mwr = 1'b1;
              s_nxt.mwdata = mem_rdata;
            end else begin
              s_nxt.work = mem_rdata;
            end
          end
          default: begin
            s_nxt.work = mem_rdata;
            s_nxt.zero = (mem_rdata == 8'h00);
          end
        endcase
      end
      default: begin
        s_nxt.st = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '{st: st_idle, work: WORK_RESET, carry: 1'b0, zero: 1'b0, bank: BANK_RESET,
               latch: LATCH_RESET, ptr0: PTR_RESET, ptr1: PTR_RESET, op: no_op,
               dest: 1'b0, maddr: PTR_RESET, mrd: 1'b0, mwr: 1'b0, mwdata: 8'h00,
               done: 1'b0, rdata: 8'h00};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign op_ready = (s_r.st == st_idle);
  assign op_done = s_r.done;
  assign mem_addr = s_r.maddr;
  assign mem_rd = s_r.mrd;
  assign mem_wr = s_r.mwr;
  assign mem_wdata = s_r.mwdata;
  assign bus_rdata = s_r.rdata;
  assign work_reg = s_r.work;
  assign bank_select_register = s_r.bank;
  assign program_counter_high_latch = s_r.latch;
  assign carry_flag = s_r.carry;
  assign zero_flag = s_r.zero;

  // Helper terms for the checks below.
  logic take;
  logic cap_lsr;
  logic cap_move;
  logic cap_ind;
  assign take = op_valid && op_ready && !bus_wr;
  assign cap_lsr = (s_r.st == st_capture) && (s_r.op == logical_right_shift_op) && !bus_wr;
  assign cap_move = (s_r.st == st_capture) && (s_r.op == file_move_op) && !bus_wr;
  assign cap_ind = (s_r.st == st_capture) && (s_r.op == indirect_load_op) && !bus_wr;

  a_lsr_to_work: assert property (@(posedge clk) disable iff (reset)
    cap_lsr && !s_r.dest |=> work_reg == {1'b0, $past(mem_rdata[7:1])}
      && carry_flag == $past(mem_rdata[0]))
    else $error("shift into work register wrong");

  a_lsr_file_back: assert property (@(posedge clk) disable iff (reset)
    cap_lsr && s_r.dest |=> mem_wr && !mem_wdata[7] && work_reg == $past(work_reg)
      && mem_wdata[6:0] == $past(mem_rdata[7:1]))
    else $error("shift write-back wrong");

  a_lsr_zero_flag: assert property (@(posedge clk) disable iff (reset)
    cap_lsr |=> zero_flag == ($past(mem_rdata[7:1]) == 7'h00))
    else $error("shift zero flag wrong");

  a_move_zero: assert property (@(posedge clk) disable iff (reset)
    cap_move && s_r.dest |=> mem_wr && mem_wdata == $past(mem_rdata)
      && zero_flag == ($past(mem_rdata) == 8'h00))
    else $error("in-place move zero flag wrong");

  a_move_to_work: assert property (@(posedge clk) disable iff (reset)
    cap_move && !s_r.dest |=> !mem_wr && work_reg == $past(mem_rdata))
    else $error("file move to work register wrong");

  a_indirect_load: assert property (@(posedge clk) disable iff (reset)
    cap_ind |=> work_reg == $past(mem_rdata) && zero_flag == ($past(mem_rdata) == 8'h00)
      && carry_flag == $past(carry_flag))
    else $error("indirect load wrong");

  a_pre_inc_addr: assert property (@(posedge clk) disable iff (reset)
    take && op_code == indirect_load_op && !indirect_relative && !ptr_sel
      && pointer_update_mode == 2'b00
      |=> mem_rd && mem_addr == $past(s_r.ptr0) + 16'h0001 && s_r.ptr0 == mem_addr)
    else $error("pre-increment address wrong");

  a_post_dec_ptr: assert property (@(posedge clk) disable iff (reset)
    take && op_code == indirect_load_op && !indirect_relative && ptr_sel
      && pointer_update_mode == 2'b11
      |=> mem_addr == $past(s_r.ptr1) && s_r.ptr1 == $past(s_r.ptr1) - 16'h0001)
    else $error("post-decrement pointer wrong");

  a_rel_offset: assert property (@(posedge clk) disable iff (reset)
    take && op_code == indirect_load_op && indirect_relative && !ptr_sel
      |=> s_r.ptr0 == $past(s_r.ptr0)
        && mem_addr == $past(s_r.ptr0) + {{10{$past(rel_offset[5])}}, $past(rel_offset)})
    else $error("relative offset address wrong");

  a_ptr_wrap: assert property (@(posedge clk) disable iff (reset)
    take && op_code == indirect_load_op && !indirect_relative && !ptr_sel
      && pointer_update_mode == 2'b10 && s_r.ptr0 == 16'hffff |=> s_r.ptr0 == 16'h0000)
    else $error("pointer did not wrap");

  a_ptr_flags_kept: assert property (@(posedge clk) disable iff (reset)
    take && op_code == indirect_load_op
      |=> carry_flag == $past(carry_flag) && zero_flag == $past(zero_flag))
    else $error("pointer step touched a flag");

  a_port_redirect: assert property (@(posedge clk) disable iff (reset)
    take && op_code == file_move_op && file_addr == INDIRECT_PORT1_ADDR
      |=> mem_rd && mem_addr == $past(s_r.ptr1))
    else $error("indirect port not redirected");

  a_bank_literal: assert property (@(posedge clk) disable iff (reset)
    take && op_code == bank_literal_load_op
      |=> bank_select_register == $past(literal[4:0]) && op_done
        && carry_flag == $past(carry_flag) && zero_flag == $past(zero_flag))
    else $error("bank literal load wrong");

  a_latch_literal: assert property (@(posedge clk) disable iff (reset)
    take && op_code == pc_latch_literal_load_op
      |=> program_counter_high_latch == $past(literal[6:0])
        && zero_flag == $past(zero_flag))
    else $error("latch literal load wrong");

  a_work_literal: assert property (@(posedge clk) disable iff (reset)
    take && op_code == accumulator_literal_load_op
      |=> work_reg == $past(literal) && op_done && op_ready)
    else $error("work literal load wrong");

  a_file_op_time: assert property (@(posedge clk) disable iff (reset)
    take && (op_code == file_move_op || op_code == logical_right_shift_op)
      |=> !op_ready ##1 !op_ready && !op_done ##1 op_done && op_ready)
    else $error("file operation timing wrong");

endmodule

/* File: dv/move_shift_instruction_exec_test.sv */
// Self-checking testbench for the move and shift instruction execution block.
`timescale 1ns/1ns
module move_shift_instruction_exec_test;
  import msx_pkg::*;

  logic clk = 1'b0;
  logic reset = 1'b1;
  logic op_valid = 1'b0;
  op_t op_code = no_op;
  logic op_ready;
  logic op_done;
  logic [FADDR_W-1:0] file_addr = 7'h00;
  logic dest_bit = 1'b0;
  logic [7:0] literal = 8'h00;
  logic ptr_sel = 1'b0;
  logic indirect_relative = 1'b0;
  logic [1:0] pointer_update_mode = 2'h0;
  logic [OFFS_W-1:0] rel_offset = 6'h00;
  logic [PTR_W-1:0] mem_addr;
  logic mem_rd;
  logic mem_wr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata = 8'h00;
  logic [3:0] bus_addr = 4'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  logic [7:0] work_reg;
  logic [BANK_W-1:0] bank_select_register;
  logic [LATCH_W-1:0] program_counter_high_latch;
  logic carry_flag;
  logic zero_flag;

  int seed = 32'h44f07322;
  int err_total = 0;
  int checked = 0;
  int i;
  int k;
  logic [7:0] mem [0:65535];
  logic [7:0] w_m = 8'h00;
  logic c_m = 1'b0;
  logic z_m = 1'b0;
  logic [4:0] bank_m = 5'h00;
  logic [6:0] latch_m = 7'h00;
  logic [15:0] ptr_m [0:1] = '{16'h0000, 16'h0000};

  move_shift_instruction_exec #(.BUS_ADDR_W(4)) u_dut (
    .clk(clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
    .op_ready(op_ready), .op_done(op_done), .file_addr(file_addr),
    .dest_bit(dest_bit), .literal(literal), .ptr_sel(ptr_sel),
    .indirect_relative(indirect_relative), .pointer_update_mode(pointer_update_mode),
    .rel_offset(rel_offset), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .work_reg(work_reg), .bank_select_register(bank_select_register),
    .program_counter_high_latch(program_counter_high_latch),
    .carry_flag(carry_flag), .zero_flag(zero_flag)
  );

  always #50 clk = ~clk;

  // Data memory; outside a read answer the data lines toggle so stale data never matches.
  always @(posedge clk) begin
    if (mem_rd === 1'b1) mem_rdata <= mem[mem_addr];
    else mem_rdata <= ~mem_rdata;
    if (mem_wr === 1'b1) mem[mem_addr] <= mem_wdata;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  task automatic reg_expect(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    @(posedge clk);
    check(bus_rdata, exp);
  endtask

  task automatic check_all;
    reg_expect(REG_WORK, w_m);
    reg_expect(REG_STATUS, {6'h00, z_m, c_m});
    reg_expect(REG_BANK, {3'h0, bank_m});
    reg_expect(REG_LATCH, {1'b0, latch_m});
    reg_expect(REG_PTR0_LO, ptr_m[0][7:0]);
    reg_expect(REG_PTR0_HI, ptr_m[0][15:8]);
    reg_expect(REG_PTR1_LO, ptr_m[1][7:0]);
    reg_expect(REG_PTR1_HI, ptr_m[1][15:8]);
  endtask

  // File addresses 0 and 1 have no storage and stand for the pointed-to location.
  function automatic logic [15:0] file_loc(input logic [6:0] fa);
    if (fa == INDIRECT_PORT0_ADDR) return ptr_m[0];
    if (fa == INDIRECT_PORT1_ADDR) return ptr_m[1];
    return {4'h0, bank_m, fa};
  endfunction

  task automatic run_op(input op_t op, input logic [6:0] fa, input logic d,
      input logic [7:0] lit, input logic ps, input logic rel, input logic [1:0] md,
      input logic [5:0] off);
    logic [15:0] a;
    logic [7:0] r;
    logic wr_exp;
    int n;
    int lat;
    wr_exp = 1'b0;
    lat = 1;
    a = 16'h0000;
    r = 8'h00;
    // Let a write-back from the previous operation land in memory before the model reads it.
    @(posedge clk);
    case (op)
      logical_right_shift_op, file_move_op: begin
        a = file_loc(fa);
        lat = 3;
        r = mem[a];
        if (op == logical_right_shift_op) begin
          c_m = r[0];
          r = {1'b0, r[7:1]};
        end
        z_m = (r == 8'h00);
        if (d) wr_exp = 1'b1;
        else w_m = r;
      end
      indirect_load_op: begin
        lat = 3;
        if (rel) begin
          a = ptr_m[ps] + {{10{off[5]}}, off};
        end else begin
          a = md[0] ? ptr_m[ps] - 16'h0001 : ptr_m[ps] + 16'h0001;
          if (md[1]) a = ptr_m[ps];
          ptr_m[ps] = md[0] ? ptr_m[ps] - 16'h0001 : ptr_m[ps] + 16'h0001;
        end
        r = mem[a];
        w_m = r;
        z_m = (r == 8'h00);
      end
      bank_literal_load_op: bank_m = lit[4:0];
      pc_latch_literal_load_op: latch_m = lit[6:0];
      default: w_m = lit;
    endcase
    op_valid <= 1'b1;
    op_code <= op;
    file_addr <= fa;
    dest_bit <= d;
    literal <= lit;
    ptr_sel <= ps;
    indirect_relative <= rel;
    pointer_update_mode <= md;
    rel_offset <= off;
    @(posedge clk);
    check(op_ready, 1'b1);
    op_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (op_done !== 1'b1 && n < 10);
    check(n, lat);
    check(work_reg, w_m);
    check(carry_flag, c_m);
    check(zero_flag, z_m);
    check(bank_select_register, bank_m);
    check(program_counter_high_latch, latch_m);
    check(mem_wr, wr_exp);
    if (wr_exp) check(mem_wdata, r);
    if (lat == 3) check(mem_addr, a);
  endtask

  initial begin
    #3000000;
    err_total++;
    $display("Watchdog expired at t=%0t", $time);
    stop_test();
  end

  initial begin
    // Every fourth location is zero so that the zero flag is set often.
    for (i = 0; i < 65536; i++) mem[i] = (i % 4 == 0) ? 8'h00 : 8'($random(seed));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    check_all();
    reg_expect(4'hc, 8'h00);
    bus_write(4'hc, 8'h5a);
    reg_expect(4'hc, 8'h00);
    bus_write(REG_PTR0_LO, 8'hff);
    bus_write(REG_PTR0_HI, 8'hff);
    ptr_m[0] = 16'hffff;
    for (k = 0; k < 16; k++) run_op(bank_literal_load_op, 0, 0, 8'(k), 0, 0, 0, 0);
    run_op(pc_latch_literal_load_op, 0, 0, 8'h7f, 0, 0, 0, 0);
    run_op(pc_latch_literal_load_op, 0, 0, 8'h00, 0, 0, 0, 0);
    mem[file_loc(7'h10)] = 8'h01;
    run_op(logical_right_shift_op, 7'h10, 1, 0, 0, 0, 0, 0);
    run_op(accumulator_literal_load_op, 0, 0, 8'h00, 0, 0, 0, 0);
    mem[file_loc(7'h11)] = 8'h80;
    run_op(logical_right_shift_op, 7'h11, 0, 0, 0, 0, 0, 0);
    mem[file_loc(7'h7f)] = 8'h00;
    run_op(file_move_op, 7'h7f, 1, 0, 0, 0, 0, 0);
    run_op(file_move_op, 7'h11, 0, 0, 0, 0, 0, 0);
    mem[16'hffff] = 8'h03;
    run_op(logical_right_shift_op, 7'h00, 1, 0, 0, 0, 0, 0);
    run_op(file_move_op, 7'h01, 0, 0, 0, 0, 0, 0);
    // Pointer 1 starts at zero and pointer 0 at the top, so both wrap first time.
    for (k = 0; k < 4; k++) begin
      run_op(indirect_load_op, 0, 0, 0, 1, 0, 2'(k) ^ 2'b01, 0);
      run_op(indirect_load_op, 0, 0, 0, 0, 0, 2'(k), 0);
    end
    run_op(indirect_load_op, 0, 0, 0, 0, 1, 2'h1, 6'h20);
    run_op(indirect_load_op, 0, 0, 0, 1, 1, 2'h2, 6'h1f);
    check_all();
    for (i = 0; i < 60; i++) begin
      k = $unsigned($random(seed)) % 6;
      run_op(op_t'(3'(k + 1)), 7'($random(seed)), 1'($random(seed)),
        (k == 3) ? 8'($random(seed)) & 8'h0f : 8'($random(seed)), 1'($random(seed)),
        1'($random(seed)), 2'($random(seed)), 6'($random(seed)));
      if (i % 15 == 14) check_all();
    end
    stop_test();
  end

endmodule
